// file: rtl/synth_freq_set2_config_regs.sv
// Second frequency-set configuration registers of the synthesizer core.
// Assumes a plain strobe register port synchronous to ref_clk and an
// analog core that samples the decoded settings as static levels.
`timescale 1ns/1ns
`include "synth_set2_defines.svh"

module synth_freq_set2_config_regs (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    // Register port
    input  wire synth_set2_pkg::reg_addr_type regAddr,
    input  wire synth_set2_pkg::reg_word_type regWrData,
    input  wire logic                        regWrStrobe,
    input  wire logic                        regRdStrobe,
    output logic [15:0]                      regRdData,
    // Loop filter settings
    output logic [2:0]                       fourth_pole_resistor_select,
    output logic                             fourthPoleBypass,
    output logic [2:0]                       third_pole_resistor_select,
    output logic                             thirdPoleBypass,
    // Output divider settings
    output logic [2:0]                       output_divider_stage_two,
    output logic [1:0]                       output_divider_stage_one,
    output logic [6:0]                       stageTwoRatio,
    output logic [2:0]                       stageOneRatio,
    output logic                             outputStagesInUse,
    output logic                             external_oscillator_select,
    // Reference path settings
    output logic [2:0]                       detector_delay_setting,
    output logic [4:0]                       reference_scaler_setting,
    output logic                             scalerBypass,
    output logic                             scalerReserved,
    output logic [3:0]                       scalerFactor,
    output logic [7:0]                       reference_post_divider,
    output logic [7:0]                       reference_pre_divider,
    // Feedback path settings
    output logic                             feedback_prescaler_select,
    output logic [2:0]                       prescalerRatio,
    output logic [2:0]                       modulator_order_select,
    output logic [2:0]                       modulatorOrder,
    output logic [11:0]                      feedback_integer_divide,
    output logic                             feedbackOverLimit
);
    import synth_set2_pkg::*;

    // Pole code zero means the pole is bypassed
    function automatic logic pole_bypass(input pole_code_type code);
        pole_bypass = (code == 3'h0);
    endfunction : pole_bypass

    // Register storage
    reg_word_type feedbackReg_r;
    reg_word_type feedbackReg_nxt;
    reg_word_type referenceReg_r;
    reg_word_type referenceReg_nxt;
    reg_word_type filterReg_r;
    reg_word_type filterReg_nxt;
    reg_word_type bufferPoleReg_r;
    reg_word_type bufferPoleReg_nxt;
    reg_word_type oscModeReg_r;
    reg_word_type oscModeReg_nxt;
    reg_word_type rdData_r;
    reg_word_type rdData_nxt;

    // Decoded settings
    logic         fourthBypass_r;
    logic         fourthBypass_nxt;
    logic         thirdBypass_r;
    logic         thirdBypass_nxt;
    logic [6:0]   stageTwoRatio_r;
    logic [6:0]   stageTwoRatio_nxt;
    logic [2:0]   stageOneRatio_r;
    logic [2:0]   stageOneRatio_nxt;
    logic         stagesInUse_r;
    logic         stagesInUse_nxt;
    logic         scalerBypass_r;
    logic         scalerBypass_nxt;
    logic         scalerReserved_r;
    logic         scalerReserved_nxt;
    logic [3:0]   scalerFactor_r;
    logic [3:0]   scalerFactor_nxt;
    logic [2:0]   prescalerRatio_r;
    logic [2:0]   prescalerRatio_nxt;
    logic [2:0]   modOrder_r;
    logic [2:0]   modOrder_nxt;
    logic         overLimit_r;
    logic         overLimit_nxt;

    // Write and read path
    always_comb begin
        feedbackReg_nxt   = feedbackReg_r;
        referenceReg_nxt  = referenceReg_r;
        filterReg_nxt     = filterReg_r;
        bufferPoleReg_nxt = bufferPoleReg_r;
        oscModeReg_nxt    = oscModeReg_r;
        rdData_nxt        = 16'h0000;
        if (regWrStrobe) begin
            unique case (regAddr)
                `ADDR_FEEDBACK_DIV:  feedbackReg_nxt   = regWrData;
                `ADDR_REFERENCE_DIV: referenceReg_nxt  = regWrData;
                `ADDR_FILTER_OUTDIV: filterReg_nxt     = regWrData;
                `ADDR_BUFFER_POLE:   bufferPoleReg_nxt = regWrData;
                `ADDR_OSC_MODE:      oscModeReg_nxt    = regWrData & `OSC_MODE_MASK;
                default:             feedbackReg_nxt   = feedbackReg_r;
            endcase
        end
        if (regRdStrobe) begin
            unique case (regAddr)
                `ADDR_FEEDBACK_DIV:  rdData_nxt = feedbackReg_r;
                `ADDR_REFERENCE_DIV: rdData_nxt = referenceReg_r;
                `ADDR_FILTER_OUTDIV: rdData_nxt = filterReg_r;
                `ADDR_BUFFER_POLE:   rdData_nxt = bufferPoleReg_r;
                `ADDR_OSC_MODE:      rdData_nxt = oscModeReg_r;
                default:             rdData_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            feedbackReg_r   <= `RST_FEEDBACK_DIV;
            referenceReg_r  <= `RST_REFERENCE_DIV;
            filterReg_r     <= `RST_FILTER_OUTDIV;
            bufferPoleReg_r <= `RST_BUFFER_POLE;
            oscModeReg_r    <= `RST_OSC_MODE;
            rdData_r        <= 16'h0000;
        end else begin
            feedbackReg_r   <= feedbackReg_nxt;
            referenceReg_r  <= referenceReg_nxt;
            filterReg_r     <= filterReg_nxt;
            bufferPoleReg_r <= bufferPoleReg_nxt;
            oscModeReg_r    <= oscModeReg_nxt;
            rdData_r        <= rdData_nxt;
        end
    end

    // Settings decode from the next register values
    always_comb begin
        fourthBypass_nxt = pole_bypass(bufferPoleReg_nxt[`FOURTH_MSB:`FOURTH_LSB]);
        thirdBypass_nxt = pole_bypass(filterReg_nxt[`THIRD_MSB:`THIRD_LSB]);
        stageTwoRatio_nxt = 7'h00;
        if (filterReg_nxt[`STAGE2_MSB:`STAGE2_LSB] <= `STAGE2_TOP_CODE) begin
            stageTwoRatio_nxt = 7'(7'h01 << filterReg_nxt[`STAGE2_MSB:`STAGE2_LSB]);
        end
        stageOneRatio_nxt = 3'(`STAGE1_BASE + {1'b0, filterReg_nxt[`STAGE1_MSB:`STAGE1_LSB]});
        stagesInUse_nxt = !oscModeReg_nxt[`EXTOSC_BIT];
        scalerBypass_nxt   = (filterReg_nxt[`SCALER_MSB:`SCALER_LSB] == `SCALER_BYPASS_CODE);
        scalerReserved_nxt = (filterReg_nxt[`SCALER_MSB:`SCALER_LSB] < `SCALER_BYPASS_CODE)
                           || (filterReg_nxt[`SCALER_MSB:`SCALER_LSB] > `SCALER_MAX_CODE);
        scalerFactor_nxt   = 4'h1;
        if (!scalerReserved_nxt) begin
            scalerFactor_nxt = filterReg_nxt[`SCALER_MSB - 1:`SCALER_LSB];
        end
        prescalerRatio_nxt = feedbackReg_nxt[`PRESCALER_BIT] ? `PRESCALE_BY_FOUR
                                                             : `PRESCALE_BY_TWO;
        modOrder_nxt = feedbackReg_nxt[`ORDER_MSB:`ORDER_LSB];
        if (feedbackReg_nxt[`ORDER_MSB:`ORDER_LSB] > `ORDER_FOURTH) begin
            modOrder_nxt = `ORDER_FOURTH;
        end
        overLimit_nxt = (feedbackReg_nxt[`FBINT_MSB:`FBINT_LSB] > `FBINT_LIMIT);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fourthBypass_r   <= 1'b0;
            thirdBypass_r    <= 1'b0;
            stageTwoRatio_r  <= 7'h02;
            stageOneRatio_r  <= 3'h5;
            stagesInUse_r    <= 1'b1;
            scalerBypass_r   <= 1'b0;
            scalerReserved_r <= 1'b0;
            scalerFactor_r   <= 4'h4;
            prescalerRatio_r <= `PRESCALE_BY_TWO;
            modOrder_r       <= 3'h0;
            overLimit_r      <= 1'b0;
        end else begin
            fourthBypass_r   <= fourthBypass_nxt;
            thirdBypass_r    <= thirdBypass_nxt;
            stageTwoRatio_r  <= stageTwoRatio_nxt;
            stageOneRatio_r  <= stageOneRatio_nxt;
            stagesInUse_r    <= stagesInUse_nxt;
            scalerBypass_r   <= scalerBypass_nxt;
            scalerReserved_r <= scalerReserved_nxt;
            scalerFactor_r   <= scalerFactor_nxt;
            prescalerRatio_r <= prescalerRatio_nxt;
            modOrder_r       <= modOrder_nxt;
            overLimit_r      <= overLimit_nxt;
        end
    end

    // Outputs
    assign regRdData                   = rdData_r;
    assign fourth_pole_resistor_select = bufferPoleReg_r[`FOURTH_MSB:`FOURTH_LSB];
    assign fourthPoleBypass            = fourthBypass_r;
    assign third_pole_resistor_select  = filterReg_r[`THIRD_MSB:`THIRD_LSB];
    assign thirdPoleBypass             = thirdBypass_r;
    assign output_divider_stage_two    = filterReg_r[`STAGE2_MSB:`STAGE2_LSB];
    assign output_divider_stage_one    = filterReg_r[`STAGE1_MSB:`STAGE1_LSB];
    assign stageTwoRatio               = stageTwoRatio_r;
    assign stageOneRatio               = stageOneRatio_r;
    assign outputStagesInUse           = stagesInUse_r;
    assign external_oscillator_select  = oscModeReg_r[`EXTOSC_BIT];
    assign detector_delay_setting      = filterReg_r[`DELAY_MSB:`DELAY_LSB];
    assign reference_scaler_setting    = filterReg_r[`SCALER_MSB:`SCALER_LSB];
    assign scalerBypass                = scalerBypass_r;
    assign scalerReserved              = scalerReserved_r;
    assign scalerFactor                = scalerFactor_r;
    assign reference_post_divider      = referenceReg_r[`POSTDIV_MSB:`POSTDIV_LSB];
    assign reference_pre_divider       = referenceReg_r[`PREDIV_MSB:`PREDIV_LSB];
    assign feedback_prescaler_select   = feedbackReg_r[`PRESCALER_BIT];
    assign prescalerRatio              = prescalerRatio_r;
    assign modulator_order_select      = feedbackReg_r[`ORDER_MSB:`ORDER_LSB];
    assign modulatorOrder              = modOrder_r;
    assign feedback_integer_divide     = feedbackReg_r[`FBINT_MSB:`FBINT_LSB];
    assign feedbackOverLimit           = overLimit_r;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_fourth_pole_write: assert property (
        regWrStrobe && regAddr == `ADDR_BUFFER_POLE |=>
            fourth_pole_resistor_select == $past(regWrData[2:0])
            && fourthPoleBypass == ($past(regWrData[2:0]) == 3'h0))
        else $error("fourth pole setting wrong after write");

    a_third_pole_bypass: assert property (
        thirdPoleBypass == (third_pole_resistor_select == 3'h0))
        else $error("third pole bypass disagrees with code");

    a_stage_two_ratio: assert property (
        output_divider_stage_two != 3'h7 |->
            stageTwoRatio == 7'(7'h01 << output_divider_stage_two))
        else $error("stage two ratio wrong");

    a_stage_one_ratio: assert property (
        stageOneRatio == 3'(3'h4 + {1'b0, output_divider_stage_one}))
        else $error("stage one ratio wrong");

    a_scaler_decode: assert property (
        reference_scaler_setting inside {[5'h02:5'h0D]} |->
            !scalerReserved && !scalerBypass
            && scalerFactor == reference_scaler_setting[3:0])
        else $error("scaler factor wrong");

    a_post_divider_write: assert property (
        regWrStrobe && regAddr == `ADDR_REFERENCE_DIV |=>
            reference_post_divider == $past(regWrData[15:8])
            && reference_pre_divider == $past(regWrData[7:0]))
        else $error("reference dividers wrong after write");

    a_prescaler_ratio: assert property (
        prescalerRatio == (feedback_prescaler_select ? 3'h4 : 3'h2))
        else $error("prescaler ratio wrong");

    a_order_saturate: assert property (
        modulator_order_select >= 3'h4 |-> modulatorOrder == 3'h4)
        else $error("modulator order not saturated");

    a_integer_limit: assert property (
        feedbackOverLimit == (feedback_integer_divide > 12'h3FF))
        else $error("integer limit flag wrong");

    a_mode_stages: assert property (
        regWrStrobe && regAddr == `ADDR_OSC_MODE |=>
            outputStagesInUse == !$past(regWrData[5])
            && outputStagesInUse != external_oscillator_select)
        else $error("output stage use wrong for mode");

    a_read_back: assert property (
        regRdStrobe && regAddr == `ADDR_FEEDBACK_DIV |=>
            regRdData == {feedback_prescaler_select, modulator_order_select,
                          feedback_integer_divide}
            ##1 (regRdData == 16'h0000 || $past(regRdStrobe)))
        else $error("feedback register read back wrong");

    a_fourth_pole_bypass: assert property (
        fourthPoleBypass == (fourth_pole_resistor_select == 3'h0))
        else $error("fourth pole bypass disagrees with code");

    a_stage_two_top: assert property (
        output_divider_stage_two == 3'h7 |-> stageTwoRatio == 7'h00)
        else $error("stage two ratio not zero for undefined code");

    a_scaler_bypass: assert property (
        reference_scaler_setting == 5'h01 |->
            scalerBypass && !scalerReserved && scalerFactor == 4'h1)
        else $error("scaler bypass decode wrong");

    a_order_pass: assert property (
        modulator_order_select < 3'h4 |-> modulatorOrder == modulator_order_select)
        else $error("modulator order changed below saturation");

    a_feedback_write: assert property (
        regWrStrobe && regAddr == `ADDR_FEEDBACK_DIV |=>
            feedback_integer_divide == $past(regWrData[11:0])
            && feedback_prescaler_select == $past(regWrData[15]))
        else $error("feedback register wrong after write");

    a_unmapped_read: assert property (
        regRdStrobe && !(regAddr inside {[8'h14:8'h18]}) |=> regRdData == 16'h0000)
        else $error("unmapped read returned data");

    c_external_mode: cover property (
        regWrStrobe && regAddr == `ADDR_OSC_MODE && regWrData[5]);
    c_write_then_read: cover property (
        regWrStrobe && regAddr == `ADDR_FILTER_OUTDIV ##1
        regRdStrobe && regAddr == `ADDR_FILTER_OUTDIV);
    c_fourth_order: cover property (modulator_order_select == 3'h7);
    c_pole_bypass: cover property (fourthPoleBypass && thirdPoleBypass);

endmodule : synth_freq_set2_config_regs

// file: inc/synth_set2_defines.svh
// Offsets, field positions, reset values and decode constants of the
// second frequency-set configuration registers.
// Assumes an 8-bit register address and 16-bit register words.
`ifndef SYNTH_SET2_DEFINES_SVH
`define SYNTH_SET2_DEFINES_SVH

// Register offsets
`define ADDR_FEEDBACK_DIV   8'h14
`define ADDR_REFERENCE_DIV  8'h15
`define ADDR_FILTER_OUTDIV  8'h16
`define ADDR_BUFFER_POLE    8'h17
`define ADDR_OSC_MODE       8'h18

// Reset values
`define RST_FEEDBACK_DIV    16'h0028
`define RST_REFERENCE_DIV   16'h0101
`define RST_FILTER_OUTDIV   16'h8584
`define RST_BUFFER_POLE     16'h10A4
`define RST_OSC_MODE        16'h0000

// Feedback divider register fields
`define PRESCALER_BIT       15
`define ORDER_MSB           14
`define ORDER_LSB           12
`define FBINT_MSB           11
`define FBINT_LSB           0

// Reference divider register fields
`define POSTDIV_MSB         15
`define POSTDIV_LSB         8
`define PREDIV_MSB          7
`define PREDIV_LSB          0

// Filter and output divider register fields
`define THIRD_MSB           15
`define THIRD_LSB           13
`define STAGE2_MSB          12
`define STAGE2_LSB          10
`define STAGE1_MSB          9
`define STAGE1_LSB          8
`define DELAY_MSB           7
`define DELAY_LSB           5
`define SCALER_MSB          4
`define SCALER_LSB          0

// Buffer and fourth pole register fields
`define FOURTH_MSB          2
`define FOURTH_LSB          0

// Oscillator mode register fields
`define EXTOSC_BIT          5
`define OSC_MODE_MASK       16'h0020

// Decode constants
`define ORDER_FOURTH        3'h4
`define SCALER_BYPASS_CODE  5'h01
`define SCALER_MAX_CODE     5'h0D
`define FBINT_LIMIT         12'h3FF
`define STAGE1_BASE         3'h4
`define STAGE2_TOP_CODE     3'h6
`define PRESCALE_BY_TWO     3'h2
`define PRESCALE_BY_FOUR    3'h4

`endif

// file: inc/synth_set2_pkg.sv
// Types shared by the second frequency-set register bank.
// Assumes 8-bit addresses and 16-bit register words.
package synth_set2_pkg;
    typedef logic [7:0]  reg_addr_type;
    typedef logic [15:0] reg_word_type;
    typedef logic [2:0]  pole_code_type;
endpackage : synth_set2_pkg

// file: bench/synth_freq_set2_config_regs_test.sv
// Self-checking bench for the second frequency-set register bank.
// Assumes the strobe register port and static decoded setting outputs.
`timescale 1ns/1ns
`include "synth_set2_defines.svh"

module synth_freq_set2_config_regs_test;
    import synth_set2_pkg::*;

    logic          ref_clk;
    logic          rst_b;
    reg_addr_type  regAddr;
    reg_word_type  regWrData;
    logic          regWrStrobe;
    logic          regRdStrobe;
    logic [15:0]   regRdData;
    logic [2:0]    fourthSel, thirdSel, stageTwo, delaySet, prescRatio, orderSel, order;
    logic          fourthByp, thirdByp, stagesInUse, extOsc, scalerByp, scalerRes;
    logic          prescSel, overLimit;
    logic [1:0]    stageOne;
    logic [6:0]    stageTwoRatio;
    logic [2:0]    stageOneRatio;
    logic [4:0]    scalerSet;
    logic [3:0]    scalerFactor;
    logic [7:0]    postDiv, preDiv;
    logic [11:0]   fbInt;
    logic [15:0]   expQ[$];
    logic          seenRd;
    int            errors;
    int            num_checks;

    synth_freq_set2_config_regs dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .fourth_pole_resistor_select(fourthSel), .fourthPoleBypass(fourthByp),
        .third_pole_resistor_select(thirdSel), .thirdPoleBypass(thirdByp),
        .output_divider_stage_two(stageTwo), .output_divider_stage_one(stageOne),
        .stageTwoRatio(stageTwoRatio), .stageOneRatio(stageOneRatio),
        .outputStagesInUse(stagesInUse), .external_oscillator_select(extOsc),
        .detector_delay_setting(delaySet), .reference_scaler_setting(scalerSet),
        .scalerBypass(scalerByp), .scalerReserved(scalerRes), .scalerFactor(scalerFactor),
        .reference_post_divider(postDiv), .reference_pre_divider(preDiv),
        .feedback_prescaler_select(prescSel), .prescalerRatio(prescRatio),
        .modulator_order_select(orderSel), .modulatorOrder(order),
        .feedback_integer_divide(fbInt), .feedbackOverLimit(overLimit)
    );

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // One access per cycle, strobes never both high
    task automatic op(input logic isWr, input logic [7:0] a, input logic [15:0] d);
        regWrStrobe <= isWr;
        regRdStrobe <= !isWr;
        regAddr     <= a;
        regWrData   <= d;
        if (!isWr) begin
            expQ.push_back(d);
        end
        @(posedge ref_clk);
    endtask : op

    task automatic idle();
        regWrStrobe <= 1'b0;
        regRdStrobe <= 1'b0;
        @(negedge ref_clk);
    endtask : idle

    // Read data compared one cycle after each read strobe
    always @(posedge ref_clk) begin
        seenRd <= regRdStrobe;
        if (seenRd === 1'b1) begin
            check(regRdData, expQ.pop_front());
        end else if (rst_b === 1'b1) begin
            check(regRdData, 16'h0000);
        end
    end

    task automatic chk_reset();
        op(1'b0, 8'h14, `RST_FEEDBACK_DIV);
        op(1'b0, 8'h15, `RST_REFERENCE_DIV);
        op(1'b0, 8'h16, `RST_FILTER_OUTDIV);
        op(1'b0, 8'h17, `RST_BUFFER_POLE);
        op(1'b0, 8'h18, `RST_OSC_MODE);
        op(1'b0, 8'h13, 16'h0000);
        op(1'b0, 8'hFF, 16'h0000);
        idle();
        check(16'(postDiv), 16'h0001);
        check(16'(preDiv), 16'h0001);
        check(16'(prescSel), 16'h0000);
        check(16'(prescRatio), 16'h0002);
        check(16'(fbInt), 16'h0028);
        check(16'(fourthSel), 16'h0004);
        check(16'(scalerFactor), 16'h0004);
        check(16'(stageTwoRatio), 16'h0002);
        check(16'(stageOneRatio), 16'h0005);
        check(16'(stagesInUse), 16'h0001);
        @(posedge ref_clk);
    endtask : chk_reset

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        finish_test();
    end

    initial begin
        logic [2:0]  f4, t3, s2, dl, od;
        logic [1:0]  s1;
        logic [4:0]  sc;
        logic [11:0] ni;
        logic [7:0]  a;
        logic [15:0] d;
        logic [15:0] w14, w15, w16, w17, w18;
        rst_b       = 1'b0;
        regAddr     = 8'h00;
        regWrData   = 16'h0000;
        regWrStrobe = 1'b0;
        regRdStrobe = 1'b0;
        seenRd      = 1'b0;
        errors      = 0;
        num_checks  = 0;
        void'($urandom(32'h339C0EC9));
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        chk_reset();
        // Field decode sweep, integer divide crosses its limit
        for (int i = 0; i < 13; i++) begin
            f4  = 3'(i);
            t3  = 3'(i * 5);
            s2  = 3'(i);
            s1  = 2'(i);
            dl  = 3'(3 + i % 3);
            sc  = 5'(i + 1);
            od  = 3'(i);
            ni  = 12'(1018 + i);
            w17 = {13'h0000, f4};
            w16 = {t3, s2, s1, dl, sc};
            w15 = {8'(255 - i), 8'(i)};
            w14 = {i[0], od, ni};
            w18 = {10'h000, i[1], 5'h00};
            op(1'b1, 8'h17, w17);
            op(1'b1, 8'h16, w16);
            op(1'b1, 8'h15, w15);
            op(1'b1, 8'h14, w14);
            op(1'b1, 8'h18, w18);
            op(1'b0, 8'h17, w17);
            op(1'b0, 8'h16, w16);
            op(1'b0, 8'h15, w15);
            op(1'b0, 8'h14, w14);
            op(1'b0, 8'h18, w18);
            idle();
            check(16'(fourthSel), 16'(f4));
            check(16'(fourthByp), 16'(f4 == 3'h0));
            check(16'(thirdSel), 16'(t3));
            check(16'(thirdByp), 16'(t3 == 3'h0));
            check(16'(stageTwo), 16'(s2));
            check(16'(stageTwoRatio), (s2 == 3'h7) ? 16'h0000 : 16'h0001 << s2);
            check(16'(stageOne), 16'(s1));
            check(16'(stageOneRatio), 16'(s1) + 16'h0004);
            check(16'(delaySet), 16'(dl));
            check(16'(scalerSet), 16'(sc));
            check(16'(scalerByp), 16'(sc == 5'h01));
            check(16'(scalerRes), 16'h0000);
            check(16'(scalerFactor), (sc > 5'h01) ? 16'(sc) : 16'h0001);
            check(16'(postDiv), 16'(255 - i));
            check(16'(preDiv), 16'(i));
            check(16'(prescSel), 16'(i[0]));
            check(16'(prescRatio), i[0] ? 16'h0004 : 16'h0002);
            check(16'(orderSel), 16'(od));
            check(16'(order), (od > 3'h4) ? 16'h0004 : 16'(od));
            check(16'(fbInt), 16'(ni));
            check(16'(overLimit), 16'(ni > 12'h3FF));
            check(16'(extOsc), 16'(i[1]));
            check(16'(stagesInUse), 16'(!i[1]));
            @(posedge ref_clk);
        end
        // pre-divider back to one before random scaler codes
        op(1'b1, 8'h15, 16'h0101);
        // Random write then read back to back, unmapped places read zero
        for (int i = 0; i < 40; i++) begin
            a = ($urandom % 2 == 0) ? 8'(8'h14 + $urandom % 5) : 8'($urandom);
            d = 16'($urandom);
            if (a == 8'h16) begin
                d[4:0] = 5'(2 + $urandom % 12);
                d[7:5] = 3'(3 + $urandom % 2);
            end
            if (a == 8'h15) begin
                d[7:0] = 8'h01;
            end
            if (a == 8'h14) begin
                d[11:10] = 2'b00;
            end
            if (a >= 8'h14 && a <= 8'h18) begin
                op(1'b1, a, d);
                op(1'b0, a, (a == 8'h18) ? (d & `OSC_MODE_MASK) : d);
            end else begin
                op(1'b1, a, d);
                op(1'b0, a, 16'h0000);
            end
        end
        idle();
        @(posedge ref_clk);
        do_reset();
        chk_reset();
        repeat (3) @(posedge ref_clk);
        finish_test();
    end
endmodule : synth_freq_set2_config_regs_test
